// >>> hw/osc_stop_monitor.sv
`timescale 1ns/100ps
`include "osc_stop_map.svh"
module osc_stop_monitor (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   xin,
  input  wire osc_stop_pkg::bus_req_t bus,
  output logic [7:0]                  rd_data,
  output logic                        irq,
  output logic                        int_rst,
  output logic                        stop_flag
);
  import osc_stop_pkg::*;

  ctrl_t      ctrl_r;
  logic       stop_flag_r;
  logic [1:0] int_sts_r;
  logic [1:0] int_mask_r;
  logic [7:0] rd_data_r;
  logic       irq_r;
  logic       int_rst_r;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [3:0] irst_cnt_r;
  logic       running_d_r;

  logic       stop_pulse;
  logic       running;
  logic       ctrl_wr;
  logic       sts_wr;
  logic       mask_wr;
  logic       stat_rd;
  logic       stop_ev;
  logic       run_ev;
  logic [1:0] ev_vec;
  logic       irst_done;

  osc_edge_watch u_watch (
    .mclk       (mclk),
    .rst        (rst),
    .xin        (xin),
    .enable     (ctrl_r.mon_en),
    .stop_pulse (stop_pulse),
    .running    (running)
  );

  assign ctrl_wr = bus.wr && (bus.addr == `OSR_CTRL_OFS);
  assign sts_wr  = bus.wr && (bus.addr == `OSR_INT_STS_OFS);
  assign mask_wr = bus.wr && (bus.addr == `OSR_INT_MASK_OFS);
  assign stat_rd = bus.rd && (bus.addr == `OSR_STAT_OFS);

  // events only count while the monitor is armed
  assign stop_ev = stop_pulse && ctrl_r.mon_en; // R02 R03
  assign run_ev  = running && !running_d_r && ctrl_r.mon_en;
  assign ev_vec  = {run_ev, stop_ev};

  // control register: only rst (external reset) clears it, never the internal one
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= ctrl_t'(`OSR_CTRL_RESET);
    end else if (ctrl_wr) begin // R07
      ctrl_r <= ctrl_t'({6'h00, bus.wdata[`OSR_CTRL_RST_BIT], bus.wdata[`OSR_CTRL_MON_BIT]});
    end
  end

  // stop detection flag: set wins over the clear by a disabling write
  always_ff @(posedge mclk) begin
    if (rst) begin // R06
      stop_flag_r <= 1'b0;
    end else if (stop_ev) begin // R03 R05
      stop_flag_r <= 1'b1;
    end else if (ctrl_wr && !bus.wdata[`OSR_CTRL_MON_BIT]) begin // R08
      stop_flag_r <= 1'b0;
    end
  end

  // sticky interrupt status, write one to clear, new event wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_sts_r <= 2'(`OSR_STS_RESET);
    end else if (sts_wr) begin
      int_sts_r <= (int_sts_r & ~bus.wdata[1:0]) | ev_vec;
    end else begin
      int_sts_r <= int_sts_r | ev_vec;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      int_mask_r <= 2'(`OSR_MASK_RESET);
    end else if (mask_wr) begin
      int_mask_r <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(int_sts_r & int_mask_r);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      running_d_r <= 1'b0;
    end else begin
      running_d_r <= running;
    end
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data_r <= `OSR_RD_ZERO;
    end else if (bus.rd) begin
      case (bus.addr)
        `OSR_CTRL_OFS: begin
          rd_data_r <= 8'(ctrl_r);
        end
        `OSR_STAT_OFS: begin // R09
          rd_data_r <= {6'h00, running, stop_flag_r};
        end
        `OSR_INT_STS_OFS: begin
          rd_data_r <= {6'h00, int_sts_r};
        end
        `OSR_INT_MASK_OFS: begin
          rd_data_r <= {6'h00, int_mask_r};
        end
        default: begin
          rd_data_r <= `OSR_RD_ZERO;
        end
      endcase
    end else begin
      rd_data_r <= `OSR_RD_ZERO;
    end
  end

  // internal reset sequencer
  assign irst_done = (irst_cnt_r == 4'(`OSR_IRST_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (stop_ev && ctrl_r.rst_en) begin // R04
          state_nxt = ST_RESET;
        end
      end
      ST_RESET: begin
        if (irst_done) begin
          state_nxt = ST_REARM;
        end
      end
      ST_REARM: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irst_cnt_r <= 4'h0;
    end else if (state_r == ST_RESET) begin
      irst_cnt_r <= irst_cnt_r + 4'h1;
    end else begin
      irst_cnt_r <= 4'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      int_rst_r <= 1'b0;
    end else begin
      int_rst_r <= (state_nxt == ST_RESET); // R04
    end
  end

  assign rd_data   = rd_data_r;
  assign irq       = irq_r;
  assign int_rst   = int_rst_r;
  assign stop_flag = stop_flag_r;

  a_flag_set: // R03
  assert property (@(posedge mclk) disable iff (rst)
    stop_ev |=> stop_flag_r)
    else $error("stop detection did not set the flag");

  a_rst_start: // R04
  assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_RUN && stop_ev && ctrl_r.rst_en) |=> int_rst_r [*8] ##1 !int_rst_r)
    else $error("internal reset not eight cycles after stop");

  a_rst_gated: // R04
  assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_RUN && !(stop_ev && ctrl_r.rst_en)) |=> !int_rst_r)
    else $error("internal reset without enabled stop");

  a_flag_kept: // R05
  assert property (@(posedge mclk) disable iff (rst)
    (int_rst_r && stop_flag_r && !ctrl_wr) |=> stop_flag_r)
    else $error("flag lost during internal reset");

  a_ext_clear: // R06
  assert property (@(posedge mclk)
    rst |=> !stop_flag_r && !ctrl_r.mon_en)
    else $error("external reset left flag or enable set");

  a_en_kept: // R07
  assert property (@(posedge mclk) disable iff (rst)
    (int_rst_r && !ctrl_wr) |=> $stable(ctrl_r.mon_en))
    else $error("enable changed by internal reset");

  a_wr0_clear: // R08
  assert property (@(posedge mclk) disable iff (rst)
    (ctrl_wr && !bus.wdata[`OSR_CTRL_MON_BIT] && !stop_ev) |=> !stop_flag_r && !ctrl_r.mon_en)
    else $error("disable write did not clear flag");

  a_flag_read: // R09
  assert property (@(posedge mclk) disable iff (rst)
    stat_rd |=> rd_data_r[`OSR_STAT_FLAG_BIT] == $past(stop_flag_r))
    else $error("status read does not show the flag");

  a_mon_off: // R02
  assert property (@(posedge mclk) disable iff (rst)
    (!ctrl_r.mon_en && !stop_flag_r) |=> !stop_flag_r)
    else $error("flag set while monitor disabled");

  // read data must fall back to zero in every cycle that follows no strobe
  a_rd_idle:
  assert property (@(posedge mclk) disable iff (rst)
    !bus.rd |=> rd_data_r == `OSR_RD_ZERO)
    else $error("read data not zero without a read strobe");

  a_rd_unmapped:
  assert property (@(posedge mclk) disable iff (rst)
    (bus.rd && bus.addr > `OSR_INT_MASK_OFS) |=> rd_data_r == `OSR_RD_ZERO)
    else $error("unmapped read returned nonzero data");

  a_rd_ctrl:
  assert property (@(posedge mclk) disable iff (rst)
    (bus.rd && bus.addr == `OSR_CTRL_OFS) |=> rd_data_r == 8'($past(ctrl_r)))
    else $error("control read does not show the control bits");

  a_rd_events:
  assert property (@(posedge mclk) disable iff (rst)
    (bus.rd && bus.addr == `OSR_INT_STS_OFS) |=> rd_data_r[1:0] == $past(int_sts_r))
    else $error("event status read does not show the status bits");

  a_rd_running: // R09
  assert property (@(posedge mclk) disable iff (rst)
    stat_rd |=> rd_data_r[`OSR_STAT_RUN_BIT] == $past(running))
    else $error("status read does not show the running bit");

  a_ctrl_write:
  assert property (@(posedge mclk) disable iff (rst)
    ctrl_wr |=> {ctrl_r.rst_en, ctrl_r.mon_en} == 2'($past(bus.wdata)))
    else $error("control write did not land");

  a_ctrl_hold: // R07
  assert property (@(posedge mclk) disable iff (rst)
    !ctrl_wr |=> $stable(ctrl_r))
    else $error("control bits changed without a write");

  a_mask_write:
  assert property (@(posedge mclk) disable iff (rst)
    mask_wr |=> int_mask_r == 2'($past(bus.wdata)))
    else $error("mask write did not land");

  a_stop_event: // R03
  assert property (@(posedge mclk) disable iff (rst)
    stop_ev |=> int_sts_r[`OSR_EV_STOP_BIT])
    else $error("stop did not set its event bit");

  a_run_event:
  assert property (@(posedge mclk) disable iff (rst)
    run_ev |=> int_sts_r[`OSR_EV_RUN_BIT])
    else $error("resumed oscillation did not set its event bit");

  a_sts_clear:
  assert property (@(posedge mclk) disable iff (rst)
    (sts_wr && bus.wdata[`OSR_EV_STOP_BIT] && !stop_ev) |=> !int_sts_r[`OSR_EV_STOP_BIT])
    else $error("write one did not clear the stop event bit");

  a_irq_on:
  assert property (@(posedge mclk) disable iff (rst)
    (|(int_sts_r & int_mask_r)) |=> irq_r)
    else $error("interrupt missing for an unmasked event");

  a_irq_off:
  assert property (@(posedge mclk) disable iff (rst)
    !(|(int_sts_r & int_mask_r)) |=> !irq_r)
    else $error("interrupt raised with no unmasked event");

  a_flag_cause: // R03
  assert property (@(posedge mclk) disable iff (rst)
    (!stop_flag_r && !stop_ev) |=> !stop_flag_r)
    else $error("flag set without a detected stop");

  a_rearm_quiet: // R04
  assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_REARM) |-> !int_rst_r)
    else $error("internal reset still high while rearming");

endmodule : osc_stop_monitor

// >>> hw/osc_stop_map.svh
// Overview of operation
// (R01) on-chip oscillator must run before monitoring
// (R02) monitor runs only while enable bit is 1
// (R03) detected main oscillator stop sets status flag
// (R04) stop reset enable 1 forces internal reset
// (R05) internal stop reset keeps status flag set
// (R06) external reset clears the status flag
// (R07) enable bit survives the internal stop reset
// (R08) writing enable 0 disables, clears status flag
// (R09) software reads flag to tell reset source
// (R10) stop declared after edgeless reference period window
`ifndef OSC_STOP_MAP_SVH
`define OSC_STOP_MAP_SVH

`define OSR_CTRL_OFS      4'h0
`define OSR_STAT_OFS      4'h1
`define OSR_INT_STS_OFS   4'h2
`define OSR_INT_MASK_OFS  4'h3

`define OSR_CTRL_MON_BIT  0
`define OSR_CTRL_RST_BIT  1
`define OSR_STAT_FLAG_BIT 0
`define OSR_STAT_RUN_BIT  1
`define OSR_EV_STOP_BIT   0
`define OSR_EV_RUN_BIT    1

`define OSR_CTRL_RESET    8'h00
`define OSR_MASK_RESET    8'h00
`define OSR_STS_RESET     8'h00
`define OSR_RD_ZERO       8'h00

`define OSR_MCLK_PERIOD_NS 20
`define OSR_STOP_TIME_NS   2000
`define OSR_STOP_CYC       ((`OSR_STOP_TIME_NS + `OSR_MCLK_PERIOD_NS - 1) / `OSR_MCLK_PERIOD_NS)
`define OSR_IRST_TIME_NS   160
`define OSR_IRST_CYC       ((`OSR_IRST_TIME_NS + `OSR_MCLK_PERIOD_NS - 1) / `OSR_MCLK_PERIOD_NS)

`endif

// >>> hw/osc_stop_pkg.sv
package osc_stop_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic [5:0] spare;
    logic       rst_en;
    logic       mon_en;
  } ctrl_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_RESET = 2'b01,
    ST_REARM = 2'b10
  } seq_state_t;

endpackage : osc_stop_pkg

// >>> hw/osc_edge_watch.sv
`timescale 1ns/100ps
`include "osc_stop_map.svh"
module osc_edge_watch (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic xin,
  input  wire logic enable,
  output logic      stop_pulse,
  output logic      running
);
  import osc_stop_pkg::*;

  logic       xin_s1_r;
  logic       xin_s2_r;
  logic       xin_s3_r;
  logic [6:0] cnt_r;
  logic       stop_pulse_r;
  logic       running_r;
  logic       edge_seen;
  logic       at_limit;

  // two-stage synchroniser plus a delay stage; the second and third stages feed the edge detector
  always_ff @(posedge mclk) begin
    if (rst) begin
      xin_s1_r <= 1'b0;
      xin_s2_r <= 1'b0;
      xin_s3_r <= 1'b0;
    end else begin
      xin_s1_r <= xin;
      xin_s2_r <= xin_s1_r;
      xin_s3_r <= xin_s2_r;
    end
  end

  assign edge_seen = xin_s2_r ^ xin_s3_r;
  assign at_limit  = (cnt_r == 7'(`OSR_STOP_CYC - 1));

  // reference periods since the last main oscillator edge, saturating
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= 7'h00;
    end else if (!enable || edge_seen) begin // R02 R10
      cnt_r <= 7'h00;
    end else if (!at_limit) begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  // one pulse when the window first expires, not repeated while stopped
  always_ff @(posedge mclk) begin
    if (rst) begin
      stop_pulse_r <= 1'b0;
      running_r    <= 1'b0;
    end else begin
      stop_pulse_r <= enable && !edge_seen && (cnt_r == 7'(`OSR_STOP_CYC - 2)); // R10
      running_r    <= enable && (edge_seen || !at_limit);
    end
  end

  assign stop_pulse = stop_pulse_r;
  assign running    = running_r;

  a_stop_timeout: // R10
  assert property (@(posedge mclk) disable iff (rst)
    (enable && !edge_seen && cnt_r == 7'(`OSR_STOP_CYC - 2)) |=> stop_pulse_r)
    else $error("stop not flagged at end of window");

  a_edge_no_stop: // R10
  assert property (@(posedge mclk) disable iff (rst)
    edge_seen |=> !stop_pulse_r)
    else $error("stop flagged despite a main oscillator edge");

endmodule : osc_edge_watch

// >>> test/osc_xtal_model.sv
`timescale 1ns/100ps
module osc_xtal_model #(
  parameter int HALF_NS = 100
) (
  input  wire logic run,
  output logic      xin
);
  // a stopped resonator freezes at its last level, no further edges
  initial begin
    xin = 1'b0;
    forever begin
      #HALF_NS;
      if (run) xin = ~xin;
    end
  end
endmodule : osc_xtal_model

// >>> test/osc_stop_monitor_tb.sv
`timescale 1ns/100ps
module osc_stop_monitor_tb;
  import osc_stop_pkg::*;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic       mclk;
  logic       rst;
  logic       run;
  logic       xin;
  logic       irq;
  logic       int_rst;
  logic       stop_flag;
  logic [7:0] rd_data;
  logic [7:0] v;
  bus_req_t   bus;
  int         errors;
  int         check_count;
  int         n;
  row_t       rows [6] = '{20'h00303, 20'h30303, 20'h5FF00, 20'hFA500, 20'h00101, 20'h30000};

  osc_xtal_model u_osc (.run(run), .xin(xin));
  osc_stop_monitor u_dut (.mclk(mclk), .rst(rst), .xin(xin), .bus(bus), .rd_data(rd_data),
                          .irq(irq), .int_rst(int_rst), .stop_flag(stop_flag));

  // reference clock runs from time zero, before any monitoring
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    run = 1'b0;
    bus = '0;
    errors = 0;
    check_count = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0], v);
      chk("reset value", v & ((a == 1) ? 8'h01 : 8'hFF), 8'h00);
    end
    cyc(150);
    chk("flag while disabled", {7'h00, stop_flag}, 8'h00);
    run = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("register row", v, rows[i].e);
    end
    cyc(150);
    chk("flag while running", {7'h00, stop_flag}, 8'h00);
    rd(4'h1, v);
    chk("status while running", v, 8'h02);
    run = 1'b0;
    cyc(95);
    chk("flag before window", {7'h00, stop_flag}, 8'h00);
    n = 0;
    while (stop_flag !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("flag after stop", {7'h00, stop_flag}, 8'h01);
    chk("no reset when disabled", {7'h00, int_rst}, 8'h00);
    rd(4'h1, v);
    chk("status flag read", v, 8'h01);
    rd(4'h2, v);
    chk("stop event", v, 8'h03);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(4'h3, 8'h01);
    cyc(2);
    chk("irq unmasked", {7'h00, irq}, 8'h01);
    wr(4'h2, 8'h01);
    cyc(2);
    chk("irq after clear", {7'h00, irq}, 8'h00);
    run = 1'b1;
    cyc(20);
    wr(4'h0, 8'h00);
    cyc(2);
    chk("flag after disable", {7'h00, stop_flag}, 8'h00);
    wr(4'h0, 8'h03);
    cyc(20);
    run = 1'b0;
    n = 0;
    while (int_rst !== 1'b1 && n < 130) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (int_rst === 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("internal reset length", n[7:0], 8'h08);
    chk("flag kept", {7'h00, stop_flag}, 8'h01);
    rd(4'h0, v);
    chk("control kept", v, 8'h03);
    @(posedge mclk);
    rst <= 1'b1;
    cyc(2);
    chk("flag on external reset", {7'h00, stop_flag}, 8'h00);
    @(posedge mclk);
    rst <= 1'b0;
    rd(4'h1, v);
    chk("status after external reset", v, 8'h00);
    final_report();
  end
endmodule : osc_stop_monitor_tb
